//--- src/pam_ctrl.sv
// Peripheral-side end: software registers for pin config and port data,
// plus peripheral alternate outputs passed through to the mux.
// Assumes a plain strobe bus; read data one cycle after the read strobe.
`timescale 1ns/10ps
module pam_ctrl
  import pam_pkg::*;
(
  input  wire logic       clock,
  input  wire logic       arst_n,
  pam_if.ctrl             bus,
  input  wire logic [3:0] addr,
  input  wire logic [7:0] wdata,
  input  wire logic       wr,
  input  wire logic       rd,
  output logic      [7:0] rdata,
  input  wire logic [8:0] periph_out,
  output logic            clash
);
  // ---------------------------------------------------------------
  // Register offsets
  // ---------------------------------------------------------------
  // Offsets live in the package so both ends and the bench agree

  logic [6:0] c30, c31, c32, d3;
  logic [7:0] c50, c51, c52, d5;
  logic       ttl;

  // Config reset gives code 0,0,1: floating input on every pin
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      c30 <= '1; c31 <= '0; c32 <= '0; d3 <= P3_DATA_RST;      // RULE_19
      c50 <= '1; c51 <= '0; c52 <= '0; d5 <= P5_DATA_RST;      // RULE_19
      ttl <= 1'b0;
    end else if (wr) begin
      if (addr == ADDR_P3_CFG0) c30 <= wdata[6:0];
      else if (addr == ADDR_P3_CFG1) c31 <= wdata[6:0];
      else if (addr == ADDR_P3_CFG2) c32 <= wdata[6:0];
      else if (addr == ADDR_P3_DATA) d3  <= wdata[6:0];
      else if (addr == ADDR_P5_CFG0) c50 <= wdata;
      else if (addr == ADDR_P5_CFG1) c51 <= wdata;
      else if (addr == ADDR_P5_CFG2) c52 <= wdata;
      else if (addr == ADDR_P5_DATA) d5  <= wdata;
      else if (addr == ADDR_MISC)    ttl <= wdata[0];          // Stored, no effect on pins
    end
  end

  // Read port, data stands one cycle after the strobe
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      rdata <= '0;
    end else if (rd) begin
      if (addr == ADDR_P3_CFG0) rdata <= {1'b0, c30};
      else if (addr == ADDR_P3_CFG1) rdata <= {1'b0, c31};
      else if (addr == ADDR_P3_CFG2) rdata <= {1'b0, c32};
      else if (addr == ADDR_P3_DATA) rdata <= {1'b0, d3};
      else if (addr == ADDR_P5_CFG0) rdata <= c50;
      else if (addr == ADDR_P5_CFG1) rdata <= c51;
      else if (addr == ADDR_P5_CFG2) rdata <= c52;
      else if (addr == ADDR_P5_DATA) rdata <= d5;
      else if (addr == ADDR_P3_PINS) rdata <= {1'b0, bus.p3_in};
      else if (addr == ADDR_P5_PINS) rdata <= bus.p5_in;
      else if (addr == ADDR_MISC)    rdata <= {7'h00, ttl};
      else if (addr == ADDR_ANALOG)  rdata <= {bus.analog_sel, 2'h0};
      else rdata <= 8'h00;
    end else begin
      rdata <= 8'h00;
    end
  end

  // Flags SPI master mode while the timer output owns the SSN pin and drives it high
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      clash <= 1'b0;
    end else begin
      clash <= periph_out[3] && ({c32[P3_SSN], c31[P3_SSN], c30[P3_SSN]} == CFG_ALT_PP)
               && periph_out[8];                               // RULE_05
    end
  end

  // Drive the configuration and peripheral outputs into the mux
  always_comb begin
    bus.port3_cfg_bit0 = c30;
    bus.port3_cfg_bit1 = c31;
    bus.port3_cfg_bit2 = c32;
    bus.port5_cfg_bit0 = c50;
    bus.port5_cfg_bit1 = c51;
    bus.port5_cfg_bit2 = c52;
    bus.p3_data        = d3;
    bus.p5_data        = d5;
    bus.ttl_select     = ttl;                                  // RULE_04
    bus.spi_mosi_out   = periph_out[0];
    bus.spi_miso_out   = periph_out[1];
    bus.spi_sck_out    = periph_out[2];
    bus.std_timer_out  = periph_out[3];
    bus.compare_out_1  = periph_out[4];
    bus.compare_out_2  = periph_out[5];
    bus.watchdog_out   = periph_out[6];
    bus.main_clock_out = periph_out[7];
    bus.spi_master     = periph_out[8];
  end
endmodule

//--- src/pam_if.sv
// Interface joining the pin-side mux and the peripheral-side control end.
// Assumes the testbench resolves pads from out/oe_n pairs.
`timescale 1ns/10ps
interface pam_if;
  import pam_pkg::*;
  // Per-pin configuration bits, three planes per port
  logic [6:0] port3_cfg_bit0, port3_cfg_bit1, port3_cfg_bit2;
  logic [7:0] port5_cfg_bit0, port5_cfg_bit1, port5_cfg_bit2;
  logic [6:0] p3_data;
  logic [7:0] p5_data;
  logic       ttl_select;     // Threshold select, no effect
  // Peripheral alternate outputs and their enables
  logic       spi_mosi_out, spi_miso_out, spi_sck_out, spi_master;
  logic       std_timer_out, compare_out_1, compare_out_2, watchdog_out, main_clock_out;
  // Alternate inputs delivered to peripherals
  logic       spi_mosi_in, spi_miso_in, spi_sck_in, spi_ssn_in;
  logic       std_timer_in, conv_ext_trigger, ext_irq_6, ext_irq_0, nmi_in;
  logic       capture_in_1, capture_in_2, watchdog_in, timer_ext_clock, alt_clock_source;
  logic [3:0] wake_line;
  logic [7:2] analog_sel;
  logic [6:0] p3_in;
  logic [7:0] p5_in;

  modport mux (
    input  port3_cfg_bit0, port3_cfg_bit1, port3_cfg_bit2,
    input  port5_cfg_bit0, port5_cfg_bit1, port5_cfg_bit2, p3_data, p5_data, ttl_select,
    input  spi_mosi_out, spi_miso_out, spi_sck_out, spi_master,
    input  std_timer_out, compare_out_1, compare_out_2, watchdog_out, main_clock_out,
    output spi_mosi_in, spi_miso_in, spi_sck_in, spi_ssn_in, std_timer_in, conv_ext_trigger,
    output ext_irq_6, ext_irq_0, nmi_in, capture_in_1, capture_in_2, watchdog_in,
    output timer_ext_clock, alt_clock_source, wake_line, analog_sel, p3_in, p5_in
  );
  modport ctrl (
    output port3_cfg_bit0, port3_cfg_bit1, port3_cfg_bit2,
    output port5_cfg_bit0, port5_cfg_bit1, port5_cfg_bit2, p3_data, p5_data, ttl_select,
    output spi_mosi_out, spi_miso_out, spi_sck_out, spi_master,
    output std_timer_out, compare_out_1, compare_out_2, watchdog_out, main_clock_out,
    input  spi_mosi_in, spi_miso_in, spi_sck_in, spi_ssn_in, std_timer_in, conv_ext_trigger,
    input  ext_irq_6, ext_irq_0, nmi_in, capture_in_1, capture_in_2, watchdog_in,
    input  timer_ext_clock, alt_clock_source, wake_line, analog_sel, p3_in, p5_in
  );
endinterface

//--- src/pam_mux.sv
// Pin-side end: routes pads to port logic or alternate functions.
// Assumes pads are resolved outside from pad_out / pad_oe_n; pad_in is asynchronous.
//
// Implementation choices: the strobed register port and the placing of the registers.
`timescale 1ns/10ps
module pam_mux
  import pam_pkg::*;
(
  input  wire logic       clock,
  input  wire logic       arst_n,
  pam_if.mux              bus,
  input  wire logic [6:0] p3_pad_in,
  output logic      [6:0] p3_pad_out,
  output logic      [6:0] p3_pad_oe_n,
  input  wire logic [7:0] p5_pad_in,
  output logic      [7:0] p5_pad_out,
  output logic      [7:0] p5_pad_oe_n
);
  // ---------------------------------------------------------------
  // Input synchronisers: three stages, change taken when 2 and 3 agree
  // ---------------------------------------------------------------
  logic [14:0] sync1, sync2, sync3, pin_q;
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      sync1 <= '0;
      sync2 <= '0;
      sync3 <= '0;
    end else begin
      sync1 <= {p5_pad_in, p3_pad_in};
      sync2 <= sync1;
      sync3 <= sync2;
    end
  end
  // Filter: hold last agreed value, only stages 2 and 3 consulted
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      pin_q <= '0;
    end else begin
      pin_q <= (sync2 & sync3) | (pin_q & (sync2 | sync3));
    end
  end

  // ---------------------------------------------------------------
  // Per-pin decode
  // ---------------------------------------------------------------
  logic [14:0] alt_pp, alt_od, gpo_on, gpo_od, analog, drive, drv_val, pin_view;
  logic [14:0] alt_val;
  logic [14:0] gpo_val;
  // Port data of both ports in pin order, avoids a negative index below
  assign gpo_val = {bus.p5_data, bus.p3_data};
  logic [2:0]  code [15];
  always_comb begin
    for (int i = 0; i < 7; i++) begin
      code[i] = {bus.port3_cfg_bit2[i], bus.port3_cfg_bit1[i], bus.port3_cfg_bit0[i]};
    end
    for (int i = 0; i < 8; i++) begin
      code[7+i] = {bus.port5_cfg_bit2[i], bus.port5_cfg_bit1[i], bus.port5_cfg_bit0[i]};
    end
  end
  // Alternate output source per pin; SPI lines take their outputs whatever the master/slave role
  always_comb begin
    alt_val = '1;
    alt_val[P3_MOSI] = bus.spi_mosi_out;                       // RULE_12
    alt_val[P3_MISO] = bus.spi_miso_out;                       // RULE_12
    alt_val[P3_SCK]  = bus.spi_sck_out;                        // RULE_13
    alt_val[P3_SSN]  = bus.std_timer_out;                      // RULE_13
    alt_val[P3_TRG]  = bus.compare_out_2;                      // RULE_14
    alt_val[P3_IRQ6] = bus.compare_out_1;                      // RULE_14
    alt_val[7+P5_AN3]  = bus.watchdog_out;                     // RULE_17
    alt_val[7+P5_CLKO] = bus.main_clock_out;                   // RULE_18
  end
  // Decode: threshold select deliberately unread, input is always Schmitt
  always_comb begin
    for (int i = 0; i < 15; i++) begin
      alt_pp[i] = (code[i] == CFG_ALT_PP);                     // RULE_10
      alt_od[i] = (code[i] == CFG_ALT_OD) || (code[i] == CFG_ALT_OD_WPU);
      gpo_on[i] = (code[i] == CFG_OUT_PP) || (code[i] == CFG_OUT_OD) || (code[i] == CFG_BIDIR);
      gpo_od[i] = (code[i] == CFG_OUT_OD);
      analog[i] = (i >= 7 + P5_ANLO) && (code[i] == CFG_ALT_OD); // RULE_11 RULE_07
      drive[i]  = 1'b0;
      drv_val[i] = 1'b1;
      if (alt_pp[i]) begin                                     // RULE_08
        drive[i]   = 1'b1;
        drv_val[i] = alt_val[i];
      end else if (alt_od[i] && !analog[i]) begin
        drive[i]   = !alt_val[i];
        drv_val[i] = 1'b0;
      end else if (gpo_on[i]) begin
        drv_val[i] = gpo_val[i];
        drive[i]   = gpo_od[i] ? !drv_val[i] : 1'b1;
      end
      // Driven alt output loops back; else pad value; analog cuts path
      if (analog[i]) begin
        pin_view[i] = 1'b0;                                    // RULE_03
      end else if (alt_pp[i] || alt_od[i]) begin
        pin_view[i] = alt_val[i] & pin_q[i];                   // RULE_01
      end else begin
        pin_view[i] = pin_q[i];                                // RULE_02 RULE_09 RULE_04
      end
    end
  end

  // ---------------------------------------------------------------
  // Pad drive registers; reset is floating input
  // ---------------------------------------------------------------
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      p3_pad_oe_n <= '1;                                       // RULE_19
      p5_pad_oe_n <= '1;                                       // RULE_19
      p3_pad_out  <= '0;
      p5_pad_out  <= '0;
    end else begin
      p3_pad_oe_n <= ~drive[6:0];
      p5_pad_oe_n <= ~drive[14:7];
      p3_pad_out  <= drv_val[6:0];
      p5_pad_out  <= drv_val[14:7];
    end
  end

  // ---------------------------------------------------------------
  // Alternate inputs: connected unless the pin is in analog mode, peripheral enable decides use
  // ---------------------------------------------------------------
  always_comb begin
    bus.spi_mosi_in      = pin_view[P3_MOSI];                  // RULE_12 RULE_06
    bus.spi_miso_in      = pin_view[P3_MISO];                  // RULE_12
    bus.wake_line[3]     = pin_view[P3_MISO];                  // RULE_12
    bus.std_timer_in     = pin_view[P3_SCK];                   // RULE_13
    bus.spi_sck_in       = pin_view[P3_SCK];                   // RULE_13
    bus.spi_ssn_in       = pin_view[P3_SSN];                   // RULE_13
    bus.conv_ext_trigger = pin_view[P3_TRG];                   // RULE_14
    bus.ext_irq_6        = pin_view[P3_IRQ6];                  // RULE_14
    bus.capture_in_1     = pin_view[P3_CAP1];                  // RULE_15
    bus.wake_line[2]     = pin_view[P3_CAP1];                  // RULE_15
    bus.capture_in_2     = pin_view[7+P5_CAP2];                // RULE_15
    bus.wake_line[1]     = pin_view[7+P5_CAP2];                // RULE_15
    bus.nmi_in           = pin_view[7+P5_NMI];                 // RULE_16
    bus.wake_line[0]     = pin_view[7+P5_NMI];                 // RULE_16
    bus.ext_irq_0        = pin_view[7+P5_AN2];                 // RULE_17
    bus.watchdog_in      = pin_view[7+P5_AN2];                 // RULE_17
    bus.timer_ext_clock  = pin_view[7+P5_AN3];                 // RULE_17
    bus.alt_clock_source = pin_view[7+P5_CKAF];                // RULE_18
    bus.analog_sel       = analog[14:9];                       // RULE_18 RULE_11
    bus.p3_in            = pin_view[6:0];
    bus.p5_in            = pin_view[14:7];
  end
endmodule

//--- src/pam_pkg.sv
// Package for the port alternate-function mux: pin map, config codes, reset values.
// Assumes both ends (pin-side mux and peripheral-side control) import it whole.
//
// Behaviour
// RULE_01: Alternate output loops into co-located alternate input
// RULE_02: Digital alternate inputs always follow the pin
// RULE_03: Analog open-drain mode cuts digital input
// RULE_04: Inputs always Schmitt; threshold select ignored
// RULE_05: Only one alternate function per pin
// RULE_06: Digital alternate input needs only peripheral enable
// RULE_07: Software sets analog code before converter use
// RULE_08: Software selects alternate outputs by config code
// RULE_09: Codes 101 or 001 give digital input
// RULE_10: Code 011 drives alternate output push-pull
// RULE_11: Code 111 selects analog input
// RULE_12: P3.0 MOSI, P3.1 MISO plus wake line 3
// RULE_13: P3.2 timer in/SCK, P3.3 SSN/timer out
// RULE_14: P3.4 trigger/compare 2, P3.5 irq6/compare 1
// RULE_15: P3.6 capture1/wake2, P5.0 capture2/wake1
// RULE_16: P5.1 feeds non-maskable irq and wake0
// RULE_17: P5.2 analog2/irq0/watchdog in; P5.3 analog3/clock/watchdog out
// RULE_18: P5.4-7 analog; P5.6 alt clock; P5.7 main clock
// RULE_19: Reset forces all pins floating input
package pam_pkg;
  localparam int P3_WIDTH = 7;
  localparam int P5_WIDTH = 8;
  localparam int CFG_W    = 3;

  // ---------------------------------------------------------------
  // Configuration codes {cfg2,cfg1,cfg0}
  // ---------------------------------------------------------------
  localparam logic [2:0] CFG_FLOAT_IN  = 3'h1; // 0,0,1 digital input
  localparam logic [2:0] CFG_SCHMITT_IN = 3'h5; // 1,0,1 digital input
  localparam logic [2:0] CFG_OUT_OD    = 3'h0;
  localparam logic [2:0] CFG_OUT_PP    = 3'h2;
  localparam logic [2:0] CFG_ALT_PP    = 3'h3; // 0,1,1 alternate push-pull
  localparam logic [2:0] CFG_BIDIR     = 3'h4;
  localparam logic [2:0] CFG_ALT_OD_WPU = 3'h6;
  localparam logic [2:0] CFG_ALT_OD    = 3'h7; // 1,1,1 alternate open drain / analog
  localparam logic [2:0] CFG_RESET     = CFG_FLOAT_IN;

  // ---------------------------------------------------------------
  // Pin positions
  // ---------------------------------------------------------------
  localparam int P3_MOSI = 0;
  localparam int P3_MISO = 1;
  localparam int P3_SCK  = 2;
  localparam int P3_SSN  = 3;
  localparam int P3_TRG  = 4;
  localparam int P3_IRQ6 = 5;
  localparam int P3_CAP1 = 6;
  localparam int P5_CAP2 = 0;
  localparam int P5_NMI  = 1;
  localparam int P5_AN2  = 2;
  localparam int P5_AN3  = 3;
  localparam int P5_CKAF = 6;
  localparam int P5_CLKO = 7;
  localparam int P5_ANLO = 2; // First analog pin

  // ---------------------------------------------------------------
  // Register offsets on the software port
  // ---------------------------------------------------------------
  localparam logic [3:0] ADDR_P3_CFG0 = 4'h0;
  localparam logic [3:0] ADDR_P3_CFG1 = 4'h1;
  localparam logic [3:0] ADDR_P3_CFG2 = 4'h2;
  localparam logic [3:0] ADDR_P3_DATA = 4'h3;
  localparam logic [3:0] ADDR_P5_CFG0 = 4'h4;
  localparam logic [3:0] ADDR_P5_CFG1 = 4'h5;
  localparam logic [3:0] ADDR_P5_CFG2 = 4'h6;
  localparam logic [3:0] ADDR_P5_DATA = 4'h7;
  localparam logic [3:0] ADDR_P3_PINS = 4'h8;
  localparam logic [3:0] ADDR_P5_PINS = 4'h9;
  localparam logic [3:0] ADDR_MISC    = 4'ha;
  localparam logic [3:0] ADDR_ANALOG  = 4'hb;

  localparam logic [6:0] P3_DATA_RST = 7'h7f;
  localparam logic [7:0] P5_DATA_RST = 8'hff;
endpackage

//--- testbench/pam_monitor.sv
// Checker for the pin mux: watches the interface planes, alternate lines and pads.
// Assumes tb_top instantiates it beside the interface, on the one clock.
`timescale 1ns/10ps
module pam_monitor
  import pam_pkg::*;
(
  input wire logic       clock,
  input wire logic       arst_n,
  input wire logic [6:0] port3_cfg_bit0,
  input wire logic [6:0] port3_cfg_bit1,
  input wire logic [6:0] port3_cfg_bit2,
  input wire logic [7:0] port5_cfg_bit0,
  input wire logic [7:0] port5_cfg_bit1,
  input wire logic [7:0] port5_cfg_bit2,
  input wire logic       std_timer_out,
  input wire logic       std_timer_in,
  input wire logic       spi_ssn_in,
  input wire logic       ext_irq_0,
  input wire logic [3:0] wake_line,
  input wire logic [7:2] analog_sel,
  input wire logic [6:0] p3_in,
  input wire logic [7:0] p5_in,
  input wire logic [6:0] p3_pad_oe_n,
  input wire logic [6:0] p3_pad_out,
  input wire logic [7:0] p5_pad_oe_n
);
  // ---------------------------------------------------------------
  // Per-pin codes
  // ---------------------------------------------------------------
  function automatic logic [2:0] c3(input int i);
    return {port3_cfg_bit2[i], port3_cfg_bit1[i], port3_cfg_bit0[i]};
  endfunction
  function automatic logic [2:0] c5(input int i);
    return {port5_cfg_bit2[i], port5_cfg_bit1[i], port5_cfg_bit0[i]};
  endfunction

  default clocking cb @(posedge clock); endclocking
  default disable iff (!arst_n);

  // Alternate push-pull held with a steady source, long enough to reach the pad
  sequence s_pp_held;
    (c3(P3_SSN) == CFG_ALT_PP && $stable(std_timer_out)) [*3];
  endsequence
  // Alternate output held low for three cycles: the looped input must then be low
  sequence s_out_low;
    (c3(P3_SSN) == CFG_ALT_PP && !std_timer_out) [*3];
  endsequence

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  a_reset_float: assert property ($rose(arst_n) |-> (&p3_pad_oe_n) && (&p5_pad_oe_n))
    else $error("pads driven right after reset");
  a_timer_in_map: assert property (!port3_cfg_bit1[P3_SCK] |-> std_timer_in == p3_in[P3_SCK])
    else $error("timer input does not follow its pin");
  a_wake_map: assert property (!port3_cfg_bit1[1] && !port3_cfg_bit1[6] && !port5_cfg_bit1[0]
    && !port5_cfg_bit1[1] |-> wake_line == {p3_in[1], p3_in[6], p5_in[0], p5_in[1]})
    else $error("wake lines do not follow their pins");
  a_irq0_map: assert property (!port5_cfg_bit1[P5_AN2] |-> ext_irq_0 == p5_in[P5_AN2])
    else $error("interrupt 0 does not follow its pin");
  a_loop_back: assert property (s_out_low |-> !spi_ssn_in)
    else $error("alternate output not looped into select input");
  a_analog_cut: assert property ((c5(P5_AN2) == CFG_ALT_OD) [*8] |-> !p5_in[P5_AN2] && analog_sel[P5_AN2])
    else $error("analog pin still feeds digital path");
  a_alt_push: assert property (s_pp_held |-> !p3_pad_oe_n[P3_SSN] && p3_pad_out[P3_SSN] == std_timer_out)
    else $error("alternate push-pull pad wrong");
  a_input_float: assert property ((c3(P3_SCK) == CFG_SCHMITT_IN) [*3] |-> p3_pad_oe_n[P3_SCK])
    else $error("input code drives its pad");
endmodule

//--- testbench/tb_top.sv
// Testbench: both ends joined by the interface, pads resolved here.
// Assumes one 25 MHz clock; pin levels and the threshold select come from a fixed seed.
`timescale 1ns/10ps
module tb_top;
  import pam_pkg::*;
  logic       clock, arst_n, wr, rd, clash;
  logic [3:0] addr;
  logic [7:0] wdata, rdata, d, p5_ext, p5_pad_out, p5_pad_oe_n, p5_pad;
  logic [8:0] periph_out;
  logic [6:0] p3_ext, p3_pad_out, p3_pad_oe_n, p3_pad;
  logic [6:0] s3 [3];
  int         fail_count = 0, check_count = 0, cycles = 0;
  pam_if bus_if();
  // Pads: the driving end wins, otherwise the outside level
  assign p3_pad = (p3_pad_oe_n & p3_ext) | (~p3_pad_oe_n & p3_pad_out);
  assign p5_pad = (p5_pad_oe_n & p5_ext) | (~p5_pad_oe_n & p5_pad_out);
  pam_mux pam_mux_i (.clock(clock), .arst_n(arst_n), .bus(bus_if), .p3_pad_in(p3_pad),
    .p3_pad_out(p3_pad_out), .p3_pad_oe_n(p3_pad_oe_n), .p5_pad_in(p5_pad),
    .p5_pad_out(p5_pad_out), .p5_pad_oe_n(p5_pad_oe_n));
  pam_ctrl pam_ctrl_i (.clock(clock), .arst_n(arst_n), .bus(bus_if), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata(rdata), .periph_out(periph_out), .clash(clash));
  pam_monitor pam_monitor_i (.clock(clock), .arst_n(arst_n), .port3_cfg_bit0(bus_if.port3_cfg_bit0),
    .port3_cfg_bit1(bus_if.port3_cfg_bit1), .port3_cfg_bit2(bus_if.port3_cfg_bit2),
    .port5_cfg_bit0(bus_if.port5_cfg_bit0), .port5_cfg_bit1(bus_if.port5_cfg_bit1),
    .port5_cfg_bit2(bus_if.port5_cfg_bit2), .std_timer_out(bus_if.std_timer_out),
    .std_timer_in(bus_if.std_timer_in), .spi_ssn_in(bus_if.spi_ssn_in), .ext_irq_0(bus_if.ext_irq_0),
    .wake_line(bus_if.wake_line), .analog_sel(bus_if.analog_sel), .p3_in(bus_if.p3_in),
    .p5_in(bus_if.p5_in), .p3_pad_oe_n(p3_pad_oe_n), .p3_pad_out(p3_pad_out), .p5_pad_oe_n(p5_pad_oe_n));
  // ---------------------------------------------------------------
  // Bus tasks, compares, expectations
  // ---------------------------------------------------------------
  task automatic wr_reg(input logic [3:0] a, input logic [7:0] v);
    @(posedge clock);
    wr    <= 1'b1;
    addr  <= a;
    wdata <= v;
    @(posedge clock);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [3:0] a);
    @(posedge clock);
    rd   <= 1'b1;
    addr <= a;
    @(posedge clock);
    rd <= 1'b0;
    #1 d = rdata;
  endtask
  task automatic chk1(input string n, input logic e, input logic g);
    check_count++;
    if (g !== e) begin
      fail_count++;
      $display("ERROR %s expected %b seen %b", n, e, g);
    end
  endtask
  task automatic chk8(input string n, input logic [7:0] e, input logic [7:0] g);
    check_count++;
    if (g !== e) begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask
  // Reset value of each register: config planes from the floating-input code, data from the data reset values
  function automatic logic [7:0] rst_val(input int k);
    if (k < 3) return {1'b0, {7{CFG_RESET[k]}}};
    if (k == 3) return {1'b0, P3_DATA_RST};
    if (k < 7) return {8{CFG_RESET[k-4]}};
    return P5_DATA_RST;
  endfunction
  // Port 3 planes are kept in a shadow so one pin changes at a time
  task automatic cfg3(input int b, input logic [2:0] c);
    for (int k = 0; k < 3; k++) begin
      s3[k][b] = c[k];
      wr_reg(4'(k), {1'b0, s3[k]});
    end
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // ---------------------------------------------------------------
  // Clock, timeout, main sequence
  // ---------------------------------------------------------------
  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end
  // Whole run needs a few hundred cycles; a hang is cut well after
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles > 20000) begin
      fail_count++;
      end_sim();
    end
  end
  initial begin
    arst_n = 1'b0;
    wr = 1'b0;
    rd = 1'b0;
    addr = 4'h0;
    wdata = 8'h00;
    periph_out = 9'h000;
    p3_ext = 7'h00;
    p5_ext = 8'h00;
    s3 = '{7'h7f, 7'h00, 7'h00};
    void'($urandom(32'h09a57450));
    repeat (12) @(posedge clock);
    chk8("p3 oe_n in reset", 8'hff, {1'b1, p3_pad_oe_n});
    chk8("p5 oe_n in reset", 8'hff, p5_pad_oe_n);
    arst_n <= 1'b1;
    for (int k = 0; k < 8; k++) begin
      rd_reg(4'(k));
      chk8("register reset", rst_val(k), d);
    end
    // Random pins, no config step; threshold select toggled meanwhile
    for (int n = 0; n < 20; n++) begin
      p3_ext <= 7'($urandom);
      p5_ext <= 8'($urandom);
      wr_reg(4'ha, 8'($urandom) & 8'h01);
      repeat (9) @(posedge clock);
      chk1("mosi in", p3_ext[0], bus_if.spi_mosi_in);
      chk1("miso in", p3_ext[1], bus_if.spi_miso_in);
      chk8("wake lines", {4'h0, p3_ext[1], p3_ext[6], p5_ext[0], p5_ext[1]}, {4'h0, bus_if.wake_line});
      chk1("timer in", p3_ext[2], bus_if.std_timer_in);
      chk1("sck in", p3_ext[2], bus_if.spi_sck_in);
      chk1("ssn in", p3_ext[3], bus_if.spi_ssn_in);
      chk1("trigger", p3_ext[4], bus_if.conv_ext_trigger);
      chk1("irq 6", p3_ext[5], bus_if.ext_irq_6);
      chk1("capture 1", p3_ext[6], bus_if.capture_in_1);
      chk1("capture 2", p5_ext[0], bus_if.capture_in_2);
      chk1("nmi", p5_ext[1], bus_if.nmi_in);
      chk1("irq 0", p5_ext[2], bus_if.ext_irq_0);
      chk1("watchdog in", p5_ext[2], bus_if.watchdog_in);
      chk1("ext clock", p5_ext[3], bus_if.timer_ext_clock);
      chk1("alt clock", p5_ext[6], bus_if.alt_clock_source);
      chk8("p5 pins", p5_ext, bus_if.p5_in);
    end
    // Alternate push-pull on the select pin, source low then high
    cfg3(P3_SSN, CFG_ALT_PP);
    for (int v = 0; v < 2; v++) begin
      p3_ext[P3_SSN] <= ~v[0];
      periph_out <= 9'h100 | (9'(v) << 3);
      repeat (10) @(posedge clock);
      chk1("ssn oe_n", 1'b0, p3_pad_oe_n[P3_SSN]);
      chk1("ssn pad", v[0], p3_pad_out[P3_SSN]);
      chk1("ssn loop", v[0], bus_if.spi_ssn_in);
      chk1("clash", v[0], clash);
    end
    cfg3(P3_SSN, CFG_FLOAT_IN);
    // Port output on the timer pin: its input still follows the pad
    for (int v = 0; v < 2; v++) begin
      wr_reg(4'h3, 8'(v) << P3_SCK);
      cfg3(P3_SCK, CFG_OUT_PP);
      p3_ext[P3_SCK] <= ~v[0];
      repeat (10) @(posedge clock);
      chk1("timer in, port out", v[0], bus_if.std_timer_in);
      cfg3(P3_SCK, CFG_SCHMITT_IN);
      repeat (10) @(posedge clock);
      chk1("schmitt oe_n", 1'b1, p3_pad_oe_n[P3_SCK]);
      chk1("timer in, schmitt", ~v[0], bus_if.std_timer_in);
    end
    // All analog-capable pins to code 111 with the pads pulled high
    p5_ext <= 8'hff;
    for (int k = 0; k < 3; k++)
      wr_reg(4'(4 + k), 8'hfc);
    repeat (10) @(posedge clock);
    chk8("p5 oe_n analog", 8'hff, p5_pad_oe_n);
    chk8("p5 pad_out analog", 8'hff, p5_pad_out);
    chk8("analog select", 8'hfc, {bus_if.analog_sel, 2'b00});
    chk8("p5 pin view", 8'h03, bus_if.p5_in);
    chk1("irq 0 cut", 1'b0, bus_if.ext_irq_0);
    // Unmapped place: write ignored, read gives zero
    wr_reg(4'hf, 8'h5a);
    rd_reg(4'hf);
    chk8("unmapped read", 8'h00, d);
    rd_reg(4'h0);
    chk8("p3 plane 0", {1'b0, s3[0]}, d);
    end_sim();
  end
endmodule
